/* rtl/air_pkg.sv */
/*
  Constants for the right-side line input routing register bank.
  Assumes a byte-wide register port with 7-bit addresses from the
  device's control bus front end, and one 50 MHz core clock.
*/
// Behaviour
// - Routing register bit 7: 0 single-ended, 1 differential; resets 0.
// - Level code 0 gives 0 dB, code 8 gives -12 dB, 1.5 dB per step.
// - Valid level code in input-one-to-left connects it to the left mixer.
// - Level code 1111, the reset value, disconnects the input from the mixer.
// - Low three bits of input-one-to-left read zero; host writes zeros.
// - Input-one-to-right register has own mode and level, same encoding.
// - Bit 2 of input-one-to-right powers right ADC up when set; resets down.
// - Low two bits pick stepping per sample, per two samples, or none.
// - Input-two-to-right bit 7: 0 single-ended, 1 differential.
package air_pkg;

  // Register addresses.
  localparam logic [6:0] AIR_ADDR_R1_LEFT  = 7'h15;
  localparam logic [6:0] AIR_ADDR_R1_RIGHT = 7'h16;
  localparam logic [6:0] AIR_ADDR_R2_RIGHT = 7'h17;

  // Field positions.
  localparam int AIR_MODE_BIT  = 7;
  localparam int AIR_LVL_HI    = 6;
  localparam int AIR_LVL_LO    = 3;
  localparam int AIR_POWER_BIT = 2;

  // Level codes and reset values.
  localparam logic [3:0] AIR_LVL_MAX_GAIN  = 4'h8;
  localparam logic [3:0] AIR_LVL_OFF       = 4'hf;
  localparam logic [7:0] AIR_RST_R1_LEFT   = 8'h78;
  localparam logic [7:0] AIR_RST_R1_RIGHT  = 8'h78;
  localparam logic [7:0] AIR_RST_R2_RIGHT  = 8'h00;

  // Stepping modes.
  localparam logic [1:0] AIR_STEP_EVERY    = 2'h0;
  localparam logic [1:0] AIR_STEP_EVERY2   = 2'h1;

  // Sample period: 50 MHz core over a 48 kHz sample rate, rounded down.
  localparam int AIR_CLK_HZ     = 50000000;
  localparam int AIR_FS_HZ      = 48000;
  localparam int AIR_FS_CYCLES  = AIR_CLK_HZ / AIR_FS_HZ;

endpackage : air_pkg

/* rtl/air_stepper.sv */
/*
  Gain stepper for one mixer path: walks the applied level code toward
  the programmed target. Assumes a one-cycle step enable from outside.
*/
`timescale 1ns/1ps
module air_stepper
  import air_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Control.
  input  wire logic [3:0] target,
  input  wire logic       step_en,
  input  wire logic       bypass,
  // Applied level.
  output logic      [3:0] level_q
);

  logic [3:0] level_d;

  // One code per enable; disconnect and bypass take effect at once so a
  // muted path never ramps through reserved codes.
  always_comb
  begin
    level_d = level_q;
    if (bypass || target == AIR_LVL_OFF || level_q == AIR_LVL_OFF)
      level_d = target;
    else if (step_en && level_q < target)
      level_d = level_q + 4'h1;
    else if (step_en && level_q > target)
      level_d = level_q - 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      level_q <= AIR_LVL_OFF;
    else
      level_q <= level_d;
  end

endmodule : air_stepper

/* rtl/air_route_regs.sv */
/*
  Right line input routing register bank: three byte registers on the
  device's internal register port, decoded into mixer connect, level,
  input mode, right ADC power and gain stepping controls.
  Assumes the control bus front end gives one-cycle write strobes and
  samples read data combinationally in the cycle of the address.
*/
`timescale 1ns/1ps
module air_route_regs
  import air_pkg::*;
#(
  parameter int FS_CYCLES = AIR_FS_CYCLES
)
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Register port.
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // Right line input one toward left mixer.
  output logic            in1_left_diff,
  output logic            in1_left_conn,
  output logic      [3:0] in1_left_level,
  // Right line input one toward right mixer.
  output logic            in1_right_diff,
  output logic            in1_right_conn,
  output logic      [3:0] in1_right_level,
  // Right line input two and right ADC.
  output logic            in2_right_diff,
  output logic            right_adc_power,
  output logic      [1:0] right_step_mode
);

  logic [7:0]  r1l_q, r1l_d, r1r_q, r1r_d, r2r_q, r2r_d;
  logic [15:0] fs_cnt_q, fs_cnt_d;
  logic        half_q, half_d;
  logic        fs_tick, step_en, bypass;

  // Register writes; low bits of the left register are not stored.
  always_comb
  begin
    r1l_d = r1l_q;
    r1r_d = r1r_q;
    r2r_d = r2r_q;
    if (reg_wr)
    begin
      case (reg_addr)
        AIR_ADDR_R1_LEFT:  r1l_d = {reg_wdata[7:3], 3'h0};
        AIR_ADDR_R1_RIGHT: r1r_d = reg_wdata;
        AIR_ADDR_R2_RIGHT: r2r_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      r1l_q <= AIR_RST_R1_LEFT;
      r1r_q <= AIR_RST_R1_RIGHT;
      r2r_q <= AIR_RST_R2_RIGHT;
    end
    else
    begin
      r1l_q <= r1l_d;
      r1r_q <= r1r_d;
      r2r_q <= r2r_d;
    end
  end

  // Read mux; unmapped addresses read zero and drop reg_hit.
  always_comb
  begin
    reg_hit = 1'b1;
    case (reg_addr)
      AIR_ADDR_R1_LEFT:  reg_rdata = r1l_q;
      AIR_ADDR_R1_RIGHT: reg_rdata = r1r_q;
      AIR_ADDR_R2_RIGHT: reg_rdata = r2r_q;
      default:
      begin
        reg_rdata = 8'h00;
        reg_hit   = 1'b0;
      end
    endcase
  end

  // Sample-rate divider with a half-rate toggle for the slow mode.
  always_comb
  begin
    fs_tick  = (fs_cnt_q == 16'(FS_CYCLES - 1));
    fs_cnt_d = fs_tick ? 16'h0000 : fs_cnt_q + 16'h0001;
    half_d   = fs_tick ? ~half_q : half_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fs_cnt_q <= 16'h0000;
      half_q   <= 1'b0;
    end
    else
    begin
      fs_cnt_q <= fs_cnt_d;
      half_q   <= half_d;
    end
  end

  // Stepping rate from the right ADC control bits.
  always_comb
  begin
    case (r1r_q[1:0])
      AIR_STEP_EVERY:  step_en = fs_tick;
      AIR_STEP_EVERY2: step_en = fs_tick & half_q;
      default:         step_en = 1'b0;
    endcase
    bypass = r1r_q[1];
  end

  // The left path shares the right stepping rate; there is one setting.
  air_stepper u_step_left (
    .sys_clk (sys_clk),
    .reset   (reset),
    .target  (r1l_q[AIR_LVL_HI:AIR_LVL_LO]),
    .step_en (step_en),
    .bypass  (bypass),
    .level_q (in1_left_level)
  );

  air_stepper u_step_right (
    .sys_clk (sys_clk),
    .reset   (reset),
    .target  (r1r_q[AIR_LVL_HI:AIR_LVL_LO]),
    .step_en (step_en),
    .bypass  (bypass),
    .level_q (in1_right_level)
  );

  // Decoded controls; reserved codes count as not connected.
  assign in1_left_diff   = r1l_q[AIR_MODE_BIT];
  assign in1_right_diff  = r1r_q[AIR_MODE_BIT];
  assign in2_right_diff  = r2r_q[AIR_MODE_BIT];
  assign in1_left_conn   = in1_left_level <= AIR_LVL_MAX_GAIN;
  assign in1_right_conn  = in1_right_level <= AIR_LVL_MAX_GAIN;
  assign right_adc_power = r1r_q[AIR_POWER_BIT];
  assign right_step_mode = r1r_q[1:0];

  // Checks.
  a_low_bits_zero: assert property (@(posedge sys_clk) disable iff (reset)
    r1l_q[2:0] == 3'h0) else $error("reserved bits not zero");
  a_off_disconnects: assert property (@(posedge sys_clk) disable iff (reset)
    r1l_q[6:3] == AIR_LVL_OFF |=> !in1_left_conn)
    else $error("off code left connected");
  a_valid_connects: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == AIR_ADDR_R1_LEFT && reg_wdata[6:3] <= 4'h8
    ##1 r1l_q[6:3] != AIR_LVL_OFF |=> in1_left_conn)
    else $error("valid code not connected");
  a_right_connects: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == AIR_ADDR_R1_RIGHT && reg_wdata[6:3] <= 4'h8
    ##1 r1r_q[6:3] != AIR_LVL_OFF |=> in1_right_conn)
    else $error("right code not connected");
  a_power_follows: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == AIR_ADDR_R1_RIGHT |=>
    right_adc_power == $past(reg_wdata[2]))
    else $error("power bit wrong");
  a_mode_follows: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == AIR_ADDR_R2_RIGHT |=>
    in2_right_diff == $past(reg_wdata[7]))
    else $error("mode bit wrong");
  a_diff_follows: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == AIR_ADDR_R1_LEFT |=>
    in1_left_diff == $past(reg_wdata[7]))
    else $error("left mode bit wrong");
  a_step_single: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(bypass) && $past(in1_right_level) != AIR_LVL_OFF &&
    $past(r1r_q[6:3]) != AIR_LVL_OFF && $changed(in1_right_level) |->
    $past(step_en)) else $error("level moved without step");
  // The target is taken one cycle back so a write in the same cycle as the
  // jump does not look like a late update.
  a_bypass_now: assert property (@(posedge sys_clk) disable iff (reset)
    bypass |=> in1_right_level == $past(r1r_q[6:3]))
    else $error("bypass level late");
  c_write_left: cover property (@(posedge sys_clk)
    reg_wr && reg_addr == AIR_ADDR_R1_LEFT);
  c_power_up: cover property (@(posedge sys_clk) $rose(right_adc_power));
  c_ramp_step: cover property (@(posedge sys_clk)
    step_en && in1_left_level != r1l_q[6:3]);

endmodule : air_route_regs

/* test/air_route_regs_test.sv */
/*
  Self-checking bench for the right line input routing register bank.
  Assumes the bank is built with FS_CYCLES of 4 so that stepping ends fast.
*/
`timescale 1ns/1ps
module air_route_regs_test
  import air_pkg::*;
;
  localparam int FS = 4;
  logic       sys_clk, reset, reg_wr, reg_hit;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       l_diff, l_conn, r_diff, r_conn, in2_diff, power;
  logic [3:0] l_lvl, r_lvl;
  logic [1:0] step;
  int         errors, total_checks, cycles;

  air_route_regs #(.FS_CYCLES(FS)) dut (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .in1_left_diff(l_diff),
    .in1_left_conn(l_conn), .in1_left_level(l_lvl),
    .in1_right_diff(r_diff), .in1_right_conn(r_conn),
    .in1_right_level(r_lvl), .in2_right_diff(in2_diff),
    .right_adc_power(power), .right_step_mode(step));

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Writes are one-cycle strobes launched off the falling edge.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  // Reads are combinational; the address is set at the falling edge.
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  // Follows the left level to its goal; each move must be one code and,
  // after the first, spaced by exactly gap cycles.
  task automatic walk(input logic [3:0] goal, input int gap);
    logic [3:0] prev;
    int         last;
    int         n;
    prev = l_lvl;
    last = -1;
    n    = 0;
    while (l_lvl !== goal && n < 200)
    begin
      @(negedge sys_clk);
      n++;
      if (l_lvl !== prev)
      begin
        check(8'(l_lvl), 8'(goal > prev ? prev + 4'h1 : prev - 4'h1));
        if (last >= 0)
          check(8'(n - last), 8'(gap));
        last = n;
        prev = l_lvl;
      end
    end
    check(8'(l_lvl), 8'(goal));
  endtask : walk

  // Free-running 50 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well beyond the roughly 150 cycles the run needs.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      complete_run();
    end
  end

  // Main sequence of register accesses and expected effects.
  initial
  begin
    reset     = 1'b1;
    reg_wr    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    rd(7'h15, 8'h78);
    rd(7'h16, 8'h78);
    rd(7'h17, 8'h00);
    rd(7'h14, 8'h00);
    check(8'(reg_hit), 8'h00);
    check(8'(l_conn), 8'h00);
    wr(7'h15, 8'hc7);
    rd(7'h15, 8'hc0);
    check(8'(l_diff), 8'h01);
    repeat (2) @(negedge sys_clk);
    check(8'(l_lvl), 8'h08);
    check(8'(l_conn), 8'h01);
    wr(7'h15, 8'h00);
    walk(4'h0, FS);
    wr(7'h16, 8'h01);
    wr(7'h15, 8'h40);
    walk(4'h8, 2 * FS);
    wr(7'h15, 8'hc0);
    wr(7'h16, 8'h8f);
    rd(7'h16, 8'h8f);
    check(8'(power), 8'h01);
    check(8'(step), 8'h03);
    check(8'(r_diff), 8'h01);
    repeat (2) @(negedge sys_clk);
    check(8'(r_lvl), 8'h01);
    check(8'(r_conn), 8'h01);
    wr(7'h16, 8'hc6);
    repeat (2) @(negedge sys_clk);
    check(8'(r_lvl), 8'h08);
    wr(7'h16, 8'h7b);
    repeat (2) @(negedge sys_clk);
    check(8'(r_conn), 8'h00);
    check(8'(power), 8'h00);
    wr(7'h17, 8'h80);
    rd(7'h17, 8'h80);
    check(8'(in2_diff), 8'h01);
    wr(7'h15, 8'h78);
    repeat (2) @(negedge sys_clk);
    check(8'(l_conn), 8'h00);
    complete_run();
  end
endmodule : air_route_regs_test
